// >>> ifd_core.sv
/*
 * Indexed pointer decode core: executes the pointer-subtract and the
 * stack-unlink-and-return opcodes, maps file operands to data addresses,
 * and holds the file-select pointers behind an AXI4-Lite slave.
 * Assumes one core clock per instruction cycle and an issuing core on the
 * same clock that holds an instruction until instr_ready.
 */
// The address map and the AXI4-Lite slave port were left to the implementer.
// Summary of operation
// RULE1 - opcode E9h with select and six-bit literal subtracts literal from chosen pointer
// RULE2 - select 0, 1, 2 picks that pointer; no status flag changes
// RULE3 - select 3 is unlink-and-return, acting on the software stack pointer only
// RULE4 - after subtracting, load program counter from return stack top and pop it
// RULE5 - unlink-and-return is one word, two cycles; second cycle idles while fetch refills
// RULE6 - extension off: access bit 0 uses access bank, 1 uses bank select
// RULE7 - extension on, access bit 0, address up to 5Fh: stack pointer plus offset
// RULE8 - extension on, access bit 0, address above 5Fh keeps access-bank mapping
// RULE9 - indexed mapping applies to every file operand carrying an access bit
// RULE10 - stack pointer zero makes indexed addresses equal the plain access-bank ones
// RULE11 - destination bit keeps meaning: 0 to working register, 1 back to memory
// RULE12 - one configuration bit enables both the new opcodes and indexed mapping
// RULE13 - pointer subtraction is twelve bits wide, wrapping modulo 4096
// RULE14 - indexed address is twelve-bit sum of stack pointer and seven-bit offset
`timescale 1ns/1ps
module ifd_core #(
   parameter int ADDR_W = 8,
   parameter int CNT_W  = 8
) (
   // clock, reset, enable
   input  wire logic                        core_clk,
   input  wire logic                        rst_b,
   input  wire logic                        ce,
   // instruction issue
   input  wire ifd_pkg::ifd_instr_t         instr,
   output logic                             instr_ready,
   // return stack and program counter
   input  wire logic [ifd_pkg::PC_W-1:0]    top_of_return_stack,
   output ifd_pkg::ifd_ret_t                ret,
   // file operand mapping
   input  wire ifd_pkg::ifd_fref_t          fref,
   input  wire logic [3:0]                  bank_select_register,
   output logic [ifd_pkg::DA_W-1:0]         data_addr,
   output logic                             data_addr_valid,
   output logic                             dest_is_w,
   output logic [ifd_pkg::DA_W-1:0]         software_stack_pointer,
   output logic                             extension_enable_bit,
   // AXI4-Lite slave
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
   input  wire logic [2:0]                  s_axi_awprot,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output logic [1:0]                       s_axi_bresp,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   input  wire logic [ADDR_W-1:0]           s_axi_araddr,
   input  wire logic [2:0]                  s_axi_arprot,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp
);
   generate
      if (ADDR_W < 5 || CNT_W < 1 || CNT_W > 16) begin : g_bad
         $error("unsupported ADDR_W or CNT_W");
      end
   endgenerate

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      ifd_pkg::ifd_state_t                        st;
      logic [ifd_pkg::NUM_PTR-1:0][ifd_pkg::DA_W-1:0] ptr;
      logic                                       ext;
      logic [CNT_W-1:0]                           cnt;
      logic                                       aw_got;
      logic                                       w_got;
      logic [ADDR_W-1:0]                          awaddr;
      logic [31:0]                                wdata;
      logic [3:0]                                 wstrb;
      logic                                       bvalid;
      logic [1:0]                                 bresp;
      logic                                       rvalid;
      logic [31:0]                                rdata;
      logic [1:0]                                 rresp;
      ifd_pkg::ifd_ret_t                          ret;
      logic [ifd_pkg::DA_W-1:0]                   daddr;
      logic                                       dav;
      logic                                       dw;
   } ifd_core_st_t;

   localparam ifd_core_st_t ST_RST = ifd_core_st_t'('0);

   ifd_core_st_t               s_reg;
   ifd_core_st_t               s_next;
   logic [1:0]                 sel;
   logic [1:0]                 sub_idx;
   logic [ifd_pkg::LIT_W-1:0]  lit;
   logic [ifd_pkg::DA_W-1:0]   diff;
   logic [ifd_pkg::DA_W-1:0]   map_addr;
   logic                       ext_op;
   logic                       wr_fire;
   logic [31:0]                rd_data;
   logic                       rd_err;
   logic [31:0]                wr_img;

   // ------------------------------------------------------------
   // opcode fields and datapath leaves
   // ------------------------------------------------------------
   assign sel     = instr.word[ifd_pkg::SEL_HI:ifd_pkg::SEL_LO];
   assign lit     = instr.word[ifd_pkg::LIT_HI:0];
   // select 3 is redirected to the stack pointer
   assign sub_idx = (sel == ifd_pkg::SEL_UNLINK) ? ifd_pkg::SPTR_IDX : sel; // see RULE3
   // the new opcode exists only with the extension on
   assign ext_op  = instr_ready && instr.valid && s_reg.ext
                    && instr.word[ifd_pkg::OPC_HI:ifd_pkg::OPC_LO] == ifd_pkg::SUBF_OPC; // see RULE1 see RULE12

   ifd_ptr_sub #(
      .W   (ifd_pkg::DA_W),
      .K_W (ifd_pkg::LIT_W)
   ) u_sub (
      .ptr_in  (s_reg.ptr[sub_idx]),
      .lit     (lit),
      .ptr_out (diff)
   ); // see RULE13

   ifd_addr_map u_map (
      .faddr    (fref.faddr),
      .access   (fref.access),
      .ext      (s_reg.ext),
      .bank_sel (bank_select_register),
      .sptr     (s_reg.ptr[ifd_pkg::SPTR_IDX]),
      .addr     (map_addr)
   ); // see RULE6 see RULE7 see RULE8 see RULE14

   // ------------------------------------------------------------
   // register read decode
   // ------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if (s_axi_araddr == ifd_pkg::REG_CFG) begin
         rd_data[ifd_pkg::CFG_EXT] = s_reg.ext;
      end else if (s_axi_araddr == ifd_pkg::REG_PTR0) begin
         rd_data[ifd_pkg::DA_W-1:0] = s_reg.ptr[0];
      end else if (s_axi_araddr == ifd_pkg::REG_PTR1) begin
         rd_data[ifd_pkg::DA_W-1:0] = s_reg.ptr[1];
      end else if (s_axi_araddr == ifd_pkg::REG_PTR2) begin
         rd_data[ifd_pkg::DA_W-1:0] = s_reg.ptr[2];
      end else if (s_axi_araddr == ifd_pkg::REG_STAT) begin
         rd_data[ifd_pkg::STAT_BUSY] = (s_reg.st == ifd_pkg::ST_UNLINK_NOP);
         rd_data[ifd_pkg::STAT_EXT]  = s_reg.ext;
         rd_data[ifd_pkg::STAT_CNT_LO +: CNT_W] = s_reg.cnt;
      end else begin
         rd_err = 1'b1;
      end
   end

   // byte-lane merge of a write into the current register image
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

   always_comb begin
      s_next = s_reg;
      s_next.ret.load  = 1'b0;
      s_next.ret.pop   = 1'b0;
      s_next.ret.flush = 1'b0;
      wr_img           = 32'h0000_0000;
      // operand mapping for every file operand, no opcode exempted
      s_next.dav   = fref.valid; // see RULE9
      s_next.daddr = map_addr;
      s_next.dw    = !fref.dest; // see RULE11

      // bus write path
      if (s_axi_awvalid && s_axi_awready) begin
         s_next.aw_got = 1'b1;
         s_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_next.w_got = 1'b1;
         s_next.wdata = s_axi_wdata;
         s_next.wstrb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (wr_fire) begin
         s_next.aw_got = 1'b0;
         s_next.w_got  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = ifd_pkg::RESP_OKAY;
         if (s_reg.awaddr == ifd_pkg::REG_CFG) begin
            wr_img     = merge({31'h0, s_reg.ext}, s_reg.wdata, s_reg.wstrb);
            s_next.ext = wr_img[ifd_pkg::CFG_EXT]; // see RULE12
         end else if (s_reg.awaddr == ifd_pkg::REG_PTR0) begin
            wr_img        = merge({20'h0_0000, s_reg.ptr[0]}, s_reg.wdata, s_reg.wstrb);
            s_next.ptr[0] = wr_img[ifd_pkg::DA_W-1:0];
         end else if (s_reg.awaddr == ifd_pkg::REG_PTR1) begin
            wr_img        = merge({20'h0_0000, s_reg.ptr[1]}, s_reg.wdata, s_reg.wstrb);
            s_next.ptr[1] = wr_img[ifd_pkg::DA_W-1:0];
         end else if (s_reg.awaddr == ifd_pkg::REG_PTR2) begin
            wr_img        = merge({20'h0_0000, s_reg.ptr[2]}, s_reg.wdata, s_reg.wstrb);
            s_next.ptr[2] = wr_img[ifd_pkg::DA_W-1:0];
         end else if (s_reg.awaddr != ifd_pkg::REG_STAT) begin
            s_next.bresp = ifd_pkg::RESP_SLVERR;
         end
      end

      // bus read path
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = rd_data;
         s_next.rresp  = rd_err ? ifd_pkg::RESP_SLVERR : ifd_pkg::RESP_OKAY;
      end

      // instruction execution; placed after the bus so the core wins a clash
      case (s_reg.st)
         ifd_pkg::ST_RUN: begin
            if (ext_op) begin
               s_next.ptr[sub_idx] = diff; // see RULE1 see RULE2 see RULE13
               s_next.cnt          = s_reg.cnt + CNT_W'(1);
               if (sel == ifd_pkg::SEL_UNLINK) begin
                  s_next.ret.load  = 1'b1; // see RULE4
                  s_next.ret.pop   = 1'b1;
                  s_next.ret.flush = 1'b1;
                  s_next.ret.pc    = top_of_return_stack;
                  s_next.st        = ifd_pkg::ST_UNLINK_NOP; // see RULE5
               end
            end
         end
         ifd_pkg::ST_UNLINK_NOP: begin
            // idle cycle while fetch restarts from the new counter
            s_next.st = ifd_pkg::ST_RUN; // see RULE5
         end
         default: begin
            s_next.st = ifd_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= ST_RST;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // readies drop with ce so no instruction, AW, W or AR handshake is taken while frozen; bvalid and rvalid are not gated
   assign instr_ready            = ce && s_reg.st == ifd_pkg::ST_RUN;
   assign s_axi_awready          = ce && !s_reg.aw_got && !s_reg.bvalid;
   assign s_axi_wready           = ce && !s_reg.w_got && !s_reg.bvalid;
   assign s_axi_arready          = ce && !s_reg.rvalid;
   assign s_axi_bvalid           = s_reg.bvalid;
   assign s_axi_bresp            = s_reg.bresp;
   assign s_axi_rvalid           = s_reg.rvalid;
   assign s_axi_rdata            = s_reg.rdata;
   assign s_axi_rresp            = s_reg.rresp;
   assign ret                    = s_reg.ret;
   assign data_addr              = s_reg.daddr;
   assign data_addr_valid        = s_reg.dav;
   assign dest_is_w              = s_reg.dw;
   assign software_stack_pointer = s_reg.ptr[ifd_pkg::SPTR_IDX];
   assign extension_enable_bit   = s_reg.ext;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_sub_result: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE1
      ce && ext_op && sel != ifd_pkg::SEL_UNLINK
      |=> s_reg.ptr[$past(sel)] == $past(s_reg.ptr[sel]) - ifd_pkg::DA_W'($past(lit)))
      else $error("pointer subtract result wrong");

   a_sel_other_kept: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE2
      ce && ext_op && !wr_fire && sel == 2'h0 |=> $stable(s_reg.ptr[1]) && $stable(s_reg.ptr[2]))
      else $error("unselected pointer changed");

   a_unlink_sptr: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE3
      ce && ext_op && sel == ifd_pkg::SEL_UNLINK
      |=> software_stack_pointer == $past(s_reg.ptr[2]) - ifd_pkg::DA_W'($past(lit)))
      else $error("unlink did not update stack pointer");

   a_unlink_return: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE4
      ce && ext_op && sel == ifd_pkg::SEL_UNLINK
      |=> ret.load && ret.pop && ret.flush && ret.pc == $past(top_of_return_stack) ##1 !ret.load)
      else $error("return not performed once");

   a_unlink_two_cyc: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE5
      ce && ext_op && sel == ifd_pkg::SEL_UNLINK ##1 ce
      |-> s_reg.st == ifd_pkg::ST_UNLINK_NOP ##1 s_reg.st == ifd_pkg::ST_RUN)
      else $error("unlink is not two cycles");

   a_bank_map: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE6
      ce && fref.valid && fref.access |=> data_addr == {$past(bank_select_register), $past(fref.faddr)})
      else $error("banked address wrong");

   a_index_map: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE7
      ce && fref.valid && s_reg.ext && !fref.access && fref.faddr <= ifd_pkg::ACC_SPLIT
      |=> data_addr == $past(software_stack_pointer) + {5'h00, $past(fref.faddr[6:0])})
      else $error("indexed address wrong");

   a_upper_access: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE8
      ce && fref.valid && !fref.access && fref.faddr > ifd_pkg::ACC_SPLIT
      |=> data_addr == {ifd_pkg::ACC_HI_BANK, $past(fref.faddr)})
      else $error("upper access bank address wrong");

   a_zero_compat: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE10
      ce && fref.valid && !fref.access && fref.faddr <= ifd_pkg::ACC_SPLIT && software_stack_pointer == 12'h000
      |=> data_addr == {4'h0, $past(fref.faddr)})
      else $error("zero pointer not backward compatible");

   a_dest_keep: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE11
      ce && fref.valid |=> data_addr_valid && dest_is_w == !$past(fref.dest))
      else $error("destination select altered");

   a_ext_off_inert: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE12
      ce && !s_reg.ext && instr.valid && !wr_fire |=> $stable(s_reg.ptr) && !ret.load)
      else $error("extended opcode ran while disabled");

   // a low enable must hold every register, bus side included
   a_ce_freeze: assert property (@(posedge core_clk) disable iff (!rst_b)
      !ce |=> $stable(s_reg))
      else $error("state moved while enable low");
endmodule

// >>> ifd_pkg.sv
/*
 * Shared constants and carriers for the indexed pointer decode block:
 * opcode fields, data-address mapping limits, register map and reset values.
 * Assumes it is compiled before every other file of the block.
 */
package ifd_pkg;

   // ------------------------------------------------------------
   // opcode fields
   // ------------------------------------------------------------
   localparam logic [7:0] SUBF_OPC    = 8'hE9;
   localparam int         OPC_HI      = 15;
   localparam int         OPC_LO      = 8;
   localparam int         SEL_HI      = 7;
   localparam int         SEL_LO      = 6;
   localparam int         LIT_HI      = 5;
   localparam int         LIT_W       = 6;
   localparam logic [1:0] SEL_UNLINK  = 2'h3;
   localparam logic [1:0] SPTR_IDX    = 2'h2;
   localparam int         NUM_PTR     = 3;

   // ------------------------------------------------------------
   // data space and access-bank mapping
   // ------------------------------------------------------------
   localparam int         DA_W        = 12;
   localparam int         PC_W        = 21;
   localparam logic [7:0] ACC_SPLIT   = 8'h5F;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   localparam logic [3:0] ACC_LO_BANK = 4'h0;

   // ------------------------------------------------------------
   // register map (byte addresses) and fields
   // ------------------------------------------------------------
   localparam logic [7:0]  REG_CFG     = 8'h00;
   localparam logic [7:0]  REG_PTR0    = 8'h04;
   localparam logic [7:0]  REG_PTR1    = 8'h08;
   localparam logic [7:0]  REG_PTR2    = 8'h0C;
   localparam logic [7:0]  REG_STAT    = 8'h10;
   localparam int          CFG_EXT     = 0;
   localparam logic        CFG_EXT_RST = 1'b0;
   localparam int          STAT_BUSY   = 0;
   localparam int          STAT_EXT    = 1;
   localparam int          STAT_CNT_LO = 16;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef enum logic [0:0] {ST_RUN, ST_UNLINK_NOP} ifd_state_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } ifd_instr_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] faddr;
      logic       access;
      logic       dest;
   } ifd_fref_t;

   typedef struct packed {
      logic            load;
      logic            pop;
      logic            flush;
      logic [PC_W-1:0] pc;
   } ifd_ret_t;

endpackage

// >>> ifd_ptr_sub.sv
/*
 * Pointer subtractor: pointer minus zero-extended literal, modulo 2**W.
 * Assumes a purely combinational use inside the core clock domain.
 */
`timescale 1ns/1ps
module ifd_ptr_sub #(
   parameter int W   = 12,
   parameter int K_W = 6
) (
   // operands
   input  wire logic [W-1:0]   ptr_in,
   input  wire logic [K_W-1:0] lit,
   // result
   output logic [W-1:0]        ptr_out
);
   generate
      if (K_W > W) begin : g_bad
         $error("literal wider than pointer");
      end
   endgenerate

   // wraps on underflow and touches no flags
   assign ptr_out = ptr_in - W'(lit);
endmodule

// >>> ifd_addr_map.sv
/*
 * Data-address mapper for byte- and bit-oriented file operands.
 * Assumes the caller supplies the operand fields, bank select and stack pointer.
 */
`timescale 1ns/1ps
module ifd_addr_map (
   // operand
   input  wire logic [7:0]              faddr,
   input  wire logic                    access,
   // context
   input  wire logic                    ext,
   input  wire logic [3:0]              bank_sel,
   input  wire logic [ifd_pkg::DA_W-1:0] sptr,
   // result
   output logic [ifd_pkg::DA_W-1:0]     addr
);
   always_comb begin
      if (access) begin
         addr = {bank_sel, faddr}; // see RULE6
      end else if (ext && faddr <= ifd_pkg::ACC_SPLIT) begin
         // offset from stack pointer, wraps in the data space
         addr = sptr + {5'h00, faddr[6:0]}; // see RULE7 see RULE14
      end else if (faddr <= ifd_pkg::ACC_SPLIT) begin
         addr = {ifd_pkg::ACC_LO_BANK, faddr}; // see RULE6 see RULE10
      end else begin
         addr = {ifd_pkg::ACC_HI_BANK, faddr}; // see RULE8
      end
   end
endmodule

// >>> test_ifd_core.sv
/*
 * Self-checking bench for ifd_core: register access over AXI4-Lite, the
 * pointer-subtract and unlink-and-return opcodes, and operand address mapping.
 * Assumes the ifd_pkg register map and the one-cycle latencies of the core.
 */
`timescale 1ns/1ps
module test_ifd_core;
   logic                core_clk = 1'b0;
   logic                rst_b = 1'b0;
   ifd_pkg::ifd_instr_t instr = '0;
   ifd_pkg::ifd_fref_t  fref = '0;
   ifd_pkg::ifd_ret_t   ret;
   logic [20:0]         ret_top = '0;
   logic [3:0]          bank_sel = '0;
   logic                ce = 1'b1;
   logic [11:0]         daddr, sptr;
   logic                instr_ready, dvalid, dest_is_w, ext_on;
   logic                awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [7:0]          awaddr = '0, araddr = '0;
   logic [31:0]         wdata = '0, rdata, rd;
   logic [1:0]          bresp, rresp;
   int                  fails = 0, checked = 0, cyc = 0;

   always #2 core_clk = ~core_clk;

   ifd_core u_dut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .instr(instr), .instr_ready(instr_ready),
      .top_of_return_stack(ret_top), .ret(ret), .fref(fref), .bank_select_register(bank_sel), .data_addr(daddr),
      .data_addr_valid(dvalid), .dest_is_w(dest_is_w), .software_stack_pointer(sptr),
      .extension_enable_bit(ext_on), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // a hang is cut short well above the hundred or so cycles the tests need
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // readies are combinational, so they are looked at on the falling edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ah, wh, ta, tw;
      ah = 0;
      wh = 0;
      // one edge after the previous call so no signal is assigned twice at once
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ah && wh)) begin
         @(negedge core_clk);
         ta = !ah && awready === 1'b1;
         tw = !wh && wready === 1'b1;
         @(posedge core_clk);
         if (ta) begin
            ah = 1;
            awvalid <= 0;
         end
         if (tw) begin
            wh = 1;
            wvalid <= 0;
         end
      end
      do @(negedge core_clk); while (bvalid !== 1'b1);
      chk(bresp, er);
      @(posedge core_clk);
      bready <= 0;
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(negedge core_clk); while (arready !== 1'b1);
      @(posedge core_clk);
      arvalid <= 0;
      do @(negedge core_clk); while (rvalid !== 1'b1);
      rd = rdata;
      chk(rresp, er);
      @(posedge core_clk);
      rready <= 0;
   endtask

   task automatic issue(input logic [15:0] w);
      @(posedge core_clk);
      instr <= '{1'b1, w};
      do @(negedge core_clk); while (instr_ready !== 1'b1);
      @(posedge core_clk);
      instr.valid <= 0;
   endtask

   // operand is sampled at one edge, mapped address shows in the next cycle
   task automatic map(input logic [7:0] f, input logic a, input logic d, input logic [11:0] ea);
      fref <= '{1'b1, f, a, d};
      @(posedge core_clk);
      fref.valid <= 0;
      @(negedge core_clk);
      chk({dvalid, dest_is_w, daddr}, {1'b1, !d, ea});
      @(posedge core_clk);
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1;
      @(posedge core_clk);
      axi_rd(ifd_pkg::REG_CFG, ifd_pkg::RESP_OKAY);
      chk(rd[0], ifd_pkg::CFG_EXT_RST);
      axi_rd(8'h14, ifd_pkg::RESP_SLVERR);
      axi_wr(8'h18, 32'h1, ifd_pkg::RESP_SLVERR);
      $display("test reset and map done");

      issue(16'hE905);
      axi_rd(ifd_pkg::REG_PTR0, ifd_pkg::RESP_OKAY);
      chk(rd[11:0], 12'h000);
      bank_sel <= 4'h3;
      map(8'h10, 0, 0, 12'h010);
      map(8'h60, 0, 1, 12'hF60);
      map(8'h44, 1, 0, 12'h344);
      $display("test extension off done");

      axi_wr(ifd_pkg::REG_CFG, 32'h1, ifd_pkg::RESP_OKAY);
      chk(ext_on, 1'b1);
      axi_wr(ifd_pkg::REG_PTR2, 32'h3FF, ifd_pkg::RESP_OKAY);
      axi_wr(ifd_pkg::REG_PTR1, 32'h100, ifd_pkg::RESP_OKAY);
      issue(16'hE9A3);
      issue(16'hE901);
      issue(16'hE97F);
      axi_rd(ifd_pkg::REG_PTR2, ifd_pkg::RESP_OKAY);
      chk(rd[11:0], 12'h3DC);
      axi_rd(ifd_pkg::REG_PTR0, ifd_pkg::RESP_OKAY);
      chk(rd[11:0], 12'hFFF);
      axi_rd(ifd_pkg::REG_PTR1, ifd_pkg::RESP_OKAY);
      chk(rd[11:0], 12'h0C1);
      chk(ret.load, 1'b0);
      // enable low: an offered subtract must be neither taken nor executed
      ce <= 1'b0;
      instr <= '{1'b1, 16'hE901};
      @(posedge core_clk);
      @(negedge core_clk);
      chk(instr_ready, 1'b0);
      @(posedge core_clk);
      instr.valid <= 1'b0;
      ce <= 1'b1;
      axi_rd(ifd_pkg::REG_PTR0, ifd_pkg::RESP_OKAY);
      chk(rd[11:0], 12'hFFF);
      $display("test pointer subtract done");

      ret_top <= 21'h01234;
      issue(16'hE9C5);
      @(negedge core_clk);
      chk({ret.load, ret.pop, ret.flush, ret.pc}, {3'b111, 21'h01234});
      chk(instr_ready, 1'b0);
      chk(sptr, 12'h3D7);
      @(negedge core_clk);
      chk({instr_ready, ret.load, ret.pop}, 3'b100);
      axi_rd(ifd_pkg::REG_STAT, ifd_pkg::RESP_OKAY);
      chk(rd, 32'h0004_0002);
      $display("test unlink and return done");

      axi_wr(ifd_pkg::REG_PTR2, 32'hA00, ifd_pkg::RESP_OKAY);
      map(8'h2C, 0, 0, 12'hA2C);
      map(8'h5F, 0, 1, 12'hA5F);
      map(8'h60, 0, 0, 12'hF60);
      map(8'h44, 1, 1, 12'h344);
      axi_wr(ifd_pkg::REG_PTR2, 32'h0, ifd_pkg::RESP_OKAY);
      map(8'h2C, 0, 0, 12'h02C);
      axi_wr(ifd_pkg::REG_PTR2, 32'hFFF, ifd_pkg::RESP_OKAY);
      map(8'h5F, 0, 0, 12'h05E);
      $display("test indexed mapping done");
      conclude();
   end
endmodule
